// file: hdl/host_bridge_pci_status_reg.sv
// Status register of host bridge device 0 with hub link error tracking.
// Assumes configuration cycles and hub link events share clk_sys_i.
`timescale 1ns/1ps
module host_bridge_pci_status_reg
   import pci_status_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Configuration access
   input wire cfg_req_s cfg_i,
   output logic [15:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Enables from command and error-command registers
   input wire logic system_error_enable_i,
   input wire logic [7:0] error_command_reg_i,
   // Hub link events
   input wire link_event_s link_i,
   // Hub link system-error message request
   output logic serr_msg_o
);

   status_state_s state;
   status_state_s next_state;
   logic sse_flag;
   logic urr_flag;
   logic car_flag;
   logic status_hit;
   logic clr_upper;

   // Compose the status word from flags and constants
   function automatic logic [15:0] status_word(input logic signalled_system_error_flag,
                                               input logic urr,
                                               input logic car);
      logic [15:0] w;
      w = '0;
      w[DETECTED_PARITY_BIT] = 1'b0;
      w[SYSTEM_ERROR_BIT] = signalled_system_error_flag;
      w[UNSUPPORTED_REQ_BIT] = urr;
      w[COMPLETER_ABORT_BIT] = car;
      w[TARGET_ABORT_BIT] = 1'b0;
      w[SELECT_TIMING_HI:SELECT_TIMING_LO] = SELECT_TIMING_FAST;
      w[MASTER_PARITY_BIT] = 1'b0;
      w[FAST_B2B_BIT] = FAST_B2B_VALUE;
      w[CAP_LIST_BIT] = CAP_LIST_VALUE;
      return w;
   endfunction

   assign status_hit = (cfg_i.addr == PCI_STATUS_OFFSET);
   // Flags sit in the upper byte
   assign clr_upper = cfg_i.wr && status_hit && cfg_i.be[1];

   // Sticky flags
   w1c_flag u_sse
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .set_i(state.serr_msg),
      .clr_i(clr_upper && cfg_i.wdata[SYSTEM_ERROR_BIT]),
      .flag_o(sse_flag)
   );

   w1c_flag u_urr
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .set_i(link_i.unsupported_cpl),
      .clr_i(clr_upper && cfg_i.wdata[UNSUPPORTED_REQ_BIT]),
      .flag_o(urr_flag)
   );

   w1c_flag u_car
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .set_i(link_i.completer_abort_cpl),
      .clr_i(clr_upper && cfg_i.wdata[COMPLETER_ABORT_BIT]),
      .flag_o(car_flag)
   );

   always_comb
   begin
      next_state = state;
      next_state.rvalid = cfg_i.rd;
      if (cfg_i.rd)
      begin
         if (status_hit)
         begin
            next_state.rdata = status_word(sse_flag, urr_flag, car_flag);
         end
         else
         begin
            next_state.rdata = '0;
         end
      end
      // Message gated by command enable
      next_state.serr_msg = system_error_enable_i &&
         (link_i.dev0_error ||
          (link_i.completer_abort_cpl &&
           error_command_reg_i[ERROR_COMMAND_REG_CA_SERR_BIT]));
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign cfg_rdata_o = state.rdata;
   assign cfg_rvalid_o = state.rvalid;
   assign serr_msg_o = state.serr_msg;

   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   property p_parity_zero;
      cfg_i.rd ##1 cfg_rvalid_o |-> !cfg_rdata_o[DETECTED_PARITY_BIT];
   endproperty
   a_parity_zero: assert property (p_parity_zero)
      else $error("detected parity flag read as one");

   property p_sse_set;
      serr_msg_o |=> sse_flag;
   endproperty
   a_sse_set: assert property (p_sse_set)
      else $error("system error flag not set after message");

   property p_urr_set;
      link_i.unsupported_cpl ##1
         !(clr_upper && cfg_i.wdata[UNSUPPORTED_REQ_BIT]) |->
         urr_flag [*2];
   endproperty
   a_urr_set: assert property (p_urr_set)
      else $error("unsupported request flag not held");

   property p_car_read;
      car_flag && cfg_i.rd && status_hit |=>
         cfg_rvalid_o && cfg_rdata_o[COMPLETER_ABORT_BIT];
   endproperty
   a_car_read: assert property (p_car_read)
      else $error("completer abort flag not visible on read");

   property p_ca_serr;
      link_i.completer_abort_cpl && system_error_enable_i &&
         error_command_reg_i[ERROR_COMMAND_REG_CA_SERR_BIT] |=> serr_msg_o ##1 sse_flag;
   endproperty
   a_ca_serr: assert property (p_ca_serr)
      else $error("completer abort did not raise system error");

   property p_const_fields;
      cfg_rvalid_o && $past(status_hit) |->
         cfg_rdata_o[TARGET_ABORT_BIT:MASTER_PARITY_BIT] == 4'h0 &&
         cfg_rdata_o[FAST_B2B_BIT] && cfg_rdata_o[CAP_LIST_BIT];
   endproperty
   a_const_fields: assert property (p_const_fields)
      else $error("hard-wired status fields wrong");

   property p_timing_zero;
      cfg_rvalid_o |-> cfg_rdata_o[SELECT_TIMING_HI:SELECT_TIMING_LO] == 2'h0;
   endproperty
   a_timing_zero: assert property (p_timing_zero)
      else $error("select timing not fast decode");

   property p_no_serr_disabled;
      !system_error_enable_i |=> !serr_msg_o;
   endproperty
   a_no_serr_disabled: assert property (p_no_serr_disabled)
      else $error("system error message while disabled");

   property p_reserved_zero;
      cfg_rvalid_o |-> cfg_rdata_o[6:5] == 2'h0 && cfg_rdata_o[3:0] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved status bits not zero");

   property p_write_zero_keeps;
      sse_flag && !state.serr_msg && cfg_i.wr && status_hit &&
         !cfg_i.wdata[SYSTEM_ERROR_BIT] |=> sse_flag;
   endproperty
   a_write_zero_keeps: assert property (p_write_zero_keeps)
      else $error("writing zero cleared a flag");

   property p_read_answer;
      cfg_rvalid_o == $past(cfg_i.rd);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer strobe wrong");

   property p_urr_clear;
      clr_upper && cfg_i.wdata[UNSUPPORTED_REQ_BIT] &&
         !link_i.unsupported_cpl |=> !urr_flag;
   endproperty
   a_urr_clear: assert property (p_urr_clear)
      else $error("unsupported request flag not cleared");

   property p_sse_source;
      !sse_flag && !state.serr_msg |=> !sse_flag;
   endproperty
   a_sse_source: assert property (p_sse_source)
      else $error("system error flag set without message");

   property p_byte_keeps;
      urr_flag && cfg_i.wr && !cfg_i.be[1] |=> urr_flag;
   endproperty
   a_byte_keeps: assert property (p_byte_keeps)
      else $error("low byte write changed a flag");

   c_serr_sent: cover property (serr_msg_o ##1 sse_flag);
   c_flag_cleared: cover property (urr_flag ##1 !urr_flag);
   c_set_and_clear: cover property (link_i.completer_abort_cpl && clr_upper &&
                                    cfg_i.wdata[COMPLETER_ABORT_BIT]);

endmodule

// file: hdl/pci_status_pkg.sv
// Package for the host bridge status register block.
// Assumes configuration cycles use byte addresses of configuration space.
package pci_status_pkg;

   // Configuration space layout
   localparam logic [7:0] PCI_STATUS_OFFSET = 8'h06;
   localparam logic [7:0] CAPABILITY_POINTER_OFFSET = 8'h34;
   localparam logic [15:0] PCI_STATUS_RESET = 16'h0090;

   // Field positions
   localparam int DETECTED_PARITY_BIT = 15;
   localparam int SYSTEM_ERROR_BIT = 14;
   localparam int UNSUPPORTED_REQ_BIT = 13;
   localparam int COMPLETER_ABORT_BIT = 12;
   localparam int TARGET_ABORT_BIT = 11;
   localparam int SELECT_TIMING_HI = 10;
   localparam int SELECT_TIMING_LO = 9;
   localparam int MASTER_PARITY_BIT = 8;
   localparam int FAST_B2B_BIT = 7;
   localparam int CAP_LIST_BIT = 4;

   // Hard-wired field values
   localparam logic [1:0] SELECT_TIMING_FAST = 2'h0;
   localparam logic FAST_B2B_VALUE = 1'b1;
   localparam logic CAP_LIST_VALUE = 1'b1;

   // Error-command bit that routes completer aborts to system error
   localparam int ERROR_COMMAND_REG_CA_SERR_BIT = 6;

   // Configuration access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } cfg_req_s;

   // Hub link events, same clock domain
   typedef struct packed {
      logic dev0_error;
      logic unsupported_cpl;
      logic completer_abort_cpl;
   } link_event_s;

   // State of one write-one-to-clear flag
   typedef struct packed {
      logic flag;
   } flag_state_s;

   // State of the register block
   typedef struct packed {
      logic [15:0] rdata;
      logic rvalid;
      logic serr_msg;
   } status_state_s;

endpackage

// file: hdl/w1c_flag.sv
// One sticky write-one-to-clear status flag.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module w1c_flag
   import pci_status_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Control
   input wire logic set_i,
   input wire logic clr_i,
   // State
   output logic flag_o
);

   flag_state_s state;
   flag_state_s next_state;

   // Set wins over a clear in the same cycle
   always_comb
   begin
      next_state = state;
      if (set_i)
      begin
         next_state.flag = 1'b1;
      end
      else if (clr_i)
      begin
         next_state.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign flag_o = state.flag;

endmodule

// file: tb/cfg_host.sv
// Configuration software model issuing status register cycles.
// Assumes the bridge answers a read on the same edge that takes it.
`timescale 1ns/1ps
module cfg_host
   import pci_status_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Answer
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   // Request
   output cfg_req_s cfg_o
);
   initial cfg_o = '0;
   // One access, held up to the taking edge
   task automatic access(input logic rd, input logic wr,
      input logic [7:0] addr, input logic [1:0] be,
      input logic [15:0] wdata, output logic [15:0] data);
      @(posedge clk_sys_i);
      cfg_o <= '{rd, wr, addr, be, wdata};
      @(posedge clk_sys_i);
      // Released fields change pattern
      cfg_o <= '{1'b0, 1'b0, ~addr, ~be, ~wdata};
      #1;
      data = rvalid_i ? rdata_i : 'x;
   endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the host bridge status register.
// Assumes the config host model drives every configuration cycle.
`timescale 1ns/1ps
module tb;
   import pci_status_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic system_error_enable = 1'b0;
   logic [7:0] error_command_reg = 8'h00;
   link_event_s link = '0;
   cfg_req_s cfg;
   logic [15:0] rdata;
   logic rvalid;
   logic serr;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;

   host_bridge_pci_status_reg u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .cfg_i(cfg), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
      .system_error_enable_i(system_error_enable), .error_command_reg_i(error_command_reg),
      .link_i(link), .serr_msg_o(serr));
   cfg_host u_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
      .rvalid_i(rvalid), .cfg_o(cfg));

   initial
   begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task automatic finish_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp,
      input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
      logic [15:0] d;
      u_host.access(1'b1, 1'b0, addr, 2'h0, 16'h0000, d);
      chk("read data", exp, d);
      @(posedge clk_sys_i);
      #1;
      chk("read valid end", 16'h0000, {15'h0000, rvalid});
      chk("read data held", exp, rdata);
   endtask

   task automatic wr(input logic [1:0] be, input logic [15:0] wdata);
      logic [15:0] d;
      u_host.access(1'b0, 1'b1, PCI_STATUS_OFFSET, be, wdata, d);
      chk("write valid", 16'h0000, {15'h0000, rvalid});
   endtask

   // One event cycle, message checked in its one-cycle slot
   task automatic ev(input link_event_s e, input logic en,
      input logic [7:0] cmd, input logic exp);
      @(posedge clk_sys_i);
      link <= e;
      system_error_enable <= en;
      error_command_reg <= cmd;
      @(posedge clk_sys_i);
      link <= '0;
      #1;
      chk("serr_msg", {15'h0000, exp}, {15'h0000, serr});
      @(posedge clk_sys_i);
      #1;
      chk("serr_msg end", 16'h0000, {15'h0000, serr});
   endtask

   task automatic t_const();
      rd(PCI_STATUS_OFFSET, 16'h0090);
      wr(2'h3, 16'hFFFF);
      rd(PCI_STATUS_OFFSET, 16'h0090);
      rd(8'h08, 16'h0000);
      $display("test const done");
   endtask

   task automatic t_unsup();
      ev(3'b010, 1'b1, 8'h40, 1'b0);
      rd(PCI_STATUS_OFFSET, 16'h2090);
      wr(2'h3, 16'h0000);
      rd(PCI_STATUS_OFFSET, 16'h2090);
      wr(2'h1, 16'h2000);
      rd(PCI_STATUS_OFFSET, 16'h2090);
      wr(2'h2, 16'h2000);
      rd(PCI_STATUS_OFFSET, 16'h0090);
      $display("test unsupported done");
   endtask

   task automatic t_abort();
      ev(3'b001, 1'b1, 8'h40, 1'b1);
      rd(PCI_STATUS_OFFSET, 16'h5090);
      wr(2'h3, 16'h0000);
      rd(PCI_STATUS_OFFSET, 16'h5090);
      wr(2'h2, 16'h4000);
      rd(PCI_STATUS_OFFSET, 16'h1090);
      wr(2'h2, 16'h1000);
      rd(PCI_STATUS_OFFSET, 16'h0090);
      ev(3'b001, 1'b1, 8'hBF, 1'b0);
      rd(PCI_STATUS_OFFSET, 16'h1090);
      wr(2'h2, 16'h1000);
      $display("test abort done");
   endtask

   task automatic t_dev0();
      ev(3'b100, 1'b0, 8'h40, 1'b0);
      rd(PCI_STATUS_OFFSET, 16'h0090);
      ev(3'b101, 1'b1, 8'h00, 1'b1);
      rd(PCI_STATUS_OFFSET, 16'h5090);
      wr(2'h2, 16'h5000);
      rd(PCI_STATUS_OFFSET, 16'h0090);
      $display("test dev0 done");
   endtask

   task automatic t_reset();
      ev(3'b010, 1'b1, 8'h40, 1'b0);
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(PCI_STATUS_OFFSET, 16'h0090);
      $display("test reset done");
   endtask

   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_const();
      t_unsup();
      t_abort();
      t_dev0();
      t_reset();
      finish_test();
   end
endmodule
